// ==== fsc_bus.sv ====
// one byte-wide read or write cycle on the flash pins
`timescale 1ns/1ps
module fsc_bus
  import fsc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // request from the sequencer
  input wire logic start,
  input wire logic wr,
  input wire logic [FA_W-1:0] addr_in,
  input wire logic [FD_W-1:0] wdata,
  input wire logic [FD_W-1:0] dq_sync,
  output logic busy,
  output logic done,
  output logic [FD_W-1:0] rdata,
  // flash pins
  output logic cs_n,
  output logic we_n,
  output logic oe_n,
  output logic [FA_W-1:0] addr,
  output logic [FD_W-1:0] dq_out,
  output logic dq_oe
);
  typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD} fsc_bus_e;
  localparam logic [3:0] SETUP_LAST = 4'(SETUP_CYC - 1);
  localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);

  fsc_bus_e st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic wr_reg, wr_next;
  logic cs_reg, cs_next, we_reg, we_next, oe_reg, oe_next, oen_reg, oen_next, done_reg, done_next;
  logic [FA_W-1:0] a_reg, a_next;
  logic [FD_W-1:0] d_reg, d_next, r_reg, r_next;

  // cycle sequencing: setup, strobe, hold, then one idle cycle with cs high
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    wr_next = wr_reg;
    a_next = a_reg;
    d_next = d_reg;
    r_next = r_reg;
    cs_next = cs_reg;
    we_next = 1'b1;
    oe_next = 1'b1;
    oen_next = oen_reg;
    done_next = 1'b0;
    unique case (st_reg)
      B_IDLE: begin
        if (start) begin
          st_next = B_SETUP;
          cnt_next = '0;
          wr_next = wr;
          a_next = addr_in;
          d_next = wdata;
          cs_next = 1'b0; // R18
          oen_next = wr;
        end
      end
      B_SETUP: begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == SETUP_LAST) begin
          st_next = B_STROBE;
          cnt_next = '0;
          we_next = !wr_reg; // R23
          oe_next = wr_reg;
        end
      end
      B_STROBE: begin
        cnt_next = cnt_reg + 4'h1;
        we_next = !wr_reg;
        oe_next = wr_reg;
        if (cnt_reg == STROBE_LAST) begin
          st_next = B_HOLD;
          we_next = 1'b1;
          oe_next = 1'b1;
          r_next = dq_sync;
        end
      end
      B_HOLD: begin
        st_next = B_IDLE;
        cs_next = 1'b1; // R17
        oen_next = 1'b0;
        done_next = 1'b1;
      end
    endcase
  end

  // register pin drivers and state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg <= B_IDLE;
      cnt_reg <= '0;
      wr_reg <= 1'b0;
      a_reg <= '0;
      d_reg <= '0;
      r_reg <= '0;
      cs_reg <= 1'b1;
      we_reg <= 1'b1;
      oe_reg <= 1'b1;
      oen_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      wr_reg <= wr_next;
      a_reg <= a_next;
      d_reg <= d_next;
      r_reg <= r_next;
      cs_reg <= cs_next;
      we_reg <= we_next;
      oe_reg <= oe_next;
      oen_reg <= oen_next;
      done_reg <= done_next;
    end
  end

  assign busy = (st_reg != B_IDLE);
  assign done = done_reg;
  assign rdata = r_reg;
  assign cs_n = cs_reg;
  assign we_n = we_reg;
  assign oe_n = oe_reg;
  assign addr = a_reg;
  assign dq_out = d_reg;
  assign dq_oe = oen_reg;

  // write strobe only inside chip select
  a_we_in_cs: assert property (@(posedge clock) disable iff (!rst_n) // R23
    !we_n |-> !cs_n) else $error("write strobe outside chip select");
  // strobe held for its full width
  a_we_width: assert property (@(posedge clock) disable iff (!rst_n) // R23
    $fell(we_n) |-> (!we_n && !cs_n)[*5]) else $error("write strobe too short");
  // never drive data while flash drives it
  a_oe_no_drive: assert property (@(posedge clock) disable iff (!rst_n)
    !oe_n |-> !dq_oe) else $error("data driven during output enable");
endmodule : fsc_bus

// ==== fsc_ctrl.sv ====
// host controller: erase, suspend, resume, read and reset of the flash
`timescale 1ns/1ps
module fsc_ctrl
  import fsc_pkg::*;
#(
  parameter logic [FD_W-1:0] CMD_READ_ARRAY = 8'h01,
  parameter logic [FD_W-1:0] CMD_READ_STATUS = 8'h02,
  parameter logic [FD_W-1:0] CMD_CLEAR_STATUS = 8'h03,
  parameter logic [FD_W-1:0] CMD_ERASE_SETUP = 8'h04,
  parameter logic [FD_W-1:0] CMD_ERASE_CONFIRM = 8'h05,
  parameter logic [FD_W-1:0] CMD_SUSPEND = 8'h06,
  parameter logic [FD_W-1:0] CMD_RESUME = 8'h07,
  parameter logic [FA_W-1:0] BLOCK_MASK = 18'h3C000,
  parameter logic [FA_W-1:0] BOOT_BASE = 18'h3C000,
  parameter logic [CNT_W-1:0] POLL_LIMIT = CNT_W'(POLL_TIMEOUT_CYC)
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [RA_W-1:0] reg_addr,
  input wire logic [RD_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [RD_W-1:0] reg_rdata,
  // flash pins
  output logic flash_cs_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic [FA_W-1:0] flash_addr,
  output logic [FD_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [FD_W-1:0] flash_dq_in,
  output logic reset_powerdown_n,
  output logic unlock_req
);
  typedef enum logic [3:0] {
    S_IDLE, S_ER_SETUP, S_ER_CONF, S_POLL, S_SUS_CMD, S_SUS_POLL, S_SUSP, S_RES_CMD,
    S_CLR, S_RDARR, S_RD_CMD, S_RD_DATA, S_ST_CMD, S_ST_RD, S_RST_LOW, S_RST_REC
  } fsc_state_e;

  fsc_state_e st_reg, st_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [FA_W-1:0] addr_reg, addr_next, er_addr_reg, er_addr_next;
  logic [FD_W-1:0] sts_reg, sts_next, rd_reg, rd_next;
  logic unlock_en_reg, unlock_en_next, issued_reg, issued_next;
  logic susp_reg, susp_next, sus_req_reg, sus_req_next, rp_reg, rp_next, ulk_reg, ulk_next;
  logic seq_reg, seq_next, tmo_reg, tmo_next, ref_reg, ref_next, boot_reg, boot_next;
  logic [RD_W-1:0] rdata_reg, rdata_next;
  logic [FD_W-1:0] dq_sync, bus_rdata, b_data;
  logic [FA_W-1:0] b_addr;
  logic b_start, b_wr, b_busy, b_done, bus_state, cmd_wr, boot_tgt, same_blk;
  logic [2:0] op;

  ////////////////////////////////////////////////////////////////////////////
  // pin sync and bus cycle engine
  fsc_sync #(.W(FD_W)) u_sync (
    .clock(clock), .rst_n(rst_n), .din(flash_dq_in), .dout(dq_sync)
  );

  fsc_bus u_bus (
    .clock(clock), .rst_n(rst_n), .start(b_start), .wr(b_wr), .addr_in(b_addr),
    .wdata(b_data), .dq_sync(dq_sync), .busy(b_busy), .done(b_done), .rdata(bus_rdata),
    .cs_n(flash_cs_n), .we_n(flash_we_n), .oe_n(flash_oe_n), .addr(flash_addr),
    .dq_out(flash_dq_out), .dq_oe(flash_dq_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  assign cmd_wr = reg_wr && (reg_addr == REG_CMD);
  assign op = reg_wdata[2:0];
  assign boot_tgt = ((er_addr_reg & BLOCK_MASK) == BOOT_BASE);
  assign same_blk = ((addr_reg & BLOCK_MASK) == (er_addr_reg & BLOCK_MASK));

  // bus request per state
  always_comb begin
    bus_state = 1'b1;
    b_wr = 1'b1;
    b_addr = addr_reg;
    b_data = CMD_READ_ARRAY;
    unique case (st_reg)
      S_ER_SETUP: b_data = CMD_ERASE_SETUP; // R4
      S_ER_CONF: b_data = CMD_ERASE_CONFIRM; // R4
      S_SUS_CMD: b_data = CMD_SUSPEND;
      S_RES_CMD: b_data = CMD_RESUME; // R18
      S_CLR: b_data = CMD_CLEAR_STATUS; // R13
      S_RDARR, S_RD_CMD: b_data = CMD_READ_ARRAY; // R12
      S_ST_CMD: b_data = CMD_READ_STATUS;
      S_POLL, S_SUS_POLL, S_RD_DATA, S_ST_RD: b_wr = 1'b0;
      default: bus_state = 1'b0;
    endcase
    if (st_reg != S_RD_DATA) begin
      b_addr = er_addr_reg;
    end
    b_start = bus_state && !issued_reg && !b_busy;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    er_addr_next = er_addr_reg;
    sts_next = sts_reg;
    rd_next = rd_reg;
    unlock_en_next = unlock_en_reg;
    issued_next = (issued_reg || b_start) && !b_done;
    susp_next = susp_reg;
    sus_req_next = sus_req_reg;
    rp_next = 1'b1;
    ulk_next = ulk_reg;
    seq_next = seq_reg;
    tmo_next = tmo_reg;
    ref_next = ref_reg;
    boot_next = boot_reg;
    // register writes; w1c on host flags, hardware set below wins
    if (reg_wr && reg_addr == REG_CTRL) begin
      unlock_en_next = reg_wdata[CTRL_UNLOCK];
    end
    if (reg_wr && reg_addr == REG_ADDR) begin
      addr_next = reg_wdata[FA_W-1:0];
    end
    if (reg_wr && reg_addr == REG_STAT) begin
      seq_next = seq_reg && !reg_wdata[ST_SEQ_ERR];
      tmo_next = tmo_reg && !reg_wdata[ST_TIMEOUT];
      ref_next = ref_reg && !reg_wdata[ST_REFUSED];
      boot_next = boot_reg && !reg_wdata[ST_BOOT_ERR];
    end
    unique case (st_reg)
      S_IDLE: begin
        if (cmd_wr) begin
          unique case (op)
            OP_ERASE: begin
              st_next = S_ER_SETUP;
              er_addr_next = addr_reg;
              ulk_next = unlock_en_reg && ((addr_reg & BLOCK_MASK) == BOOT_BASE); // R20
            end
            OP_READ: st_next = S_RD_CMD;
            OP_STATUS: st_next = S_ST_CMD;
            OP_RESET: st_next = S_RST_LOW;
            default: ref_next = 1'b1;
          endcase
          cnt_next = '0;
        end
      end
      S_ER_SETUP: if (b_done) st_next = S_ER_CONF;
      S_ER_CONF: begin
        if (b_done) begin
          st_next = S_POLL;
          cnt_next = '0;
        end
      end
      S_POLL, S_SUS_POLL: begin
        cnt_next = cnt_reg + CNT_W'(1);
        if (b_done) begin
          sts_next = bus_rdata; // R8
          if (bus_rdata[STS_READY] && st_reg == S_SUS_POLL && bus_rdata[STS_SUSP]) begin
            st_next = S_SUSP; // R15
            susp_next = 1'b1; // R22
          end else if (bus_rdata[STS_READY]) begin
            st_next = S_CLR; // R13
            sus_req_next = 1'b0; // late suspend dropped, erase already done
            seq_next = seq_reg || (bus_rdata[STS_ERASE_FAIL] && bus_rdata[STS_PROG_FAIL]); // R6
            boot_next = boot_reg || (bus_rdata[STS_ERASE_FAIL] && boot_tgt && !ulk_reg); // R20
          end else if (sus_req_reg && st_reg == S_POLL) begin
            st_next = S_SUS_CMD; // R14
            sus_req_next = 1'b0;
          end else if (cnt_reg >= POLL_LIMIT) begin
            tmo_next = 1'b1; // R10
            st_next = S_CLR;
          end
        end
      end
      S_SUS_CMD: begin
        if (b_done) begin
          st_next = S_SUS_POLL;
          cnt_next = '0;
        end
      end
      S_SUSP: begin
        // chip select stays high here: low-current standby
        if (cmd_wr) begin
          unique case (op)
            OP_RESUME: st_next = S_RES_CMD; // R16
            OP_STATUS: st_next = S_ST_CMD; // R16
            OP_RESET: st_next = S_RST_LOW;
            OP_READ: begin
              if (same_blk) ref_next = 1'b1; // R16
              else st_next = S_RD_CMD; // R16
            end
            default: ref_next = 1'b1; // R16
          endcase
          cnt_next = '0;
        end
      end
      S_RES_CMD: begin
        if (b_done) begin
          st_next = S_POLL; // R18
          susp_next = 1'b0; // R22
          cnt_next = '0;
        end
      end
      S_CLR: if (b_done) st_next = S_RDARR; // R13
      S_RDARR: begin
        if (b_done) begin
          st_next = S_IDLE; // R12
          ulk_next = 1'b0;
        end
      end
      S_RD_CMD: if (b_done) st_next = S_RD_DATA;
      S_RD_DATA: begin
        if (b_done) begin
          rd_next = bus_rdata; // R5
          st_next = susp_reg ? S_SUSP : S_IDLE;
        end
      end
      S_ST_CMD: if (b_done) st_next = S_ST_RD;
      S_ST_RD: begin
        if (b_done) begin
          sts_next = bus_rdata;
          st_next = susp_reg ? S_SUSP : S_IDLE;
          if (susp_reg && bus_rdata[STS_SUPPLY_LOW]) begin
            st_next = S_CLR; // R3
            susp_next = 1'b0; // R3
          end
        end
      end
      S_RST_LOW: begin
        rp_next = 1'b0; // R24
        cnt_next = cnt_reg + CNT_W'(1);
        susp_next = 1'b0;
        sus_req_next = 1'b0;
        ulk_next = 1'b0;
        if (cnt_reg == CNT_W'(RP_LOW_CYC)) begin
          st_next = S_RST_REC;
          cnt_next = '0;
          rp_next = 1'b1;
        end
      end
      S_RST_REC: begin
        cnt_next = cnt_reg + CNT_W'(1);
        if (cnt_reg == CNT_W'(RP_RECOV_CYC - 1)) begin
          st_next = S_IDLE; // R21
          sts_next = '0; // R24
        end
      end
    endcase
    // suspend is only taken while an erase is being polled
    if (cmd_wr && op == OP_SUSPEND && st_reg != S_IDLE && st_reg != S_SUSP) begin
      if (st_reg == S_POLL) sus_req_next = 1'b1;
      else ref_next = 1'b1;
    end else if (cmd_wr && st_reg != S_IDLE && st_reg != S_SUSP) begin
      ref_next = 1'b1;
    end
  end

  // register read mux; data stands only the cycle after the strobe
  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: rdata_next[CTRL_UNLOCK] = unlock_en_reg;
        REG_ADDR: rdata_next[FA_W-1:0] = addr_reg;
        REG_STAT: begin
          rdata_next[FD_W-1:0] = sts_reg; // R1 R2 R11 R19 R25
          rdata_next[ST_BUSY] = (st_reg != S_IDLE) && (st_reg != S_SUSP);
          rdata_next[ST_SUSPENDED] = susp_reg;
          rdata_next[ST_SEQ_ERR] = seq_reg; // R7
          rdata_next[ST_TIMEOUT] = tmo_reg;
          rdata_next[ST_REFUSED] = ref_reg;
          rdata_next[ST_BOOT_ERR] = boot_reg;
        end
        REG_RDATA: rdata_next[FD_W-1:0] = rd_reg;
        default: rdata_next = '0;
      endcase
    end
  end

  // register all sequencer state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg <= S_IDLE;
      cnt_reg <= '0;
      addr_reg <= '0;
      er_addr_reg <= '0;
      sts_reg <= '0;
      rd_reg <= '0;
      unlock_en_reg <= 1'b0;
      issued_reg <= 1'b0;
      susp_reg <= 1'b0;
      sus_req_reg <= 1'b0;
      rp_reg <= 1'b1;
      ulk_reg <= 1'b0;
      seq_reg <= 1'b0;
      tmo_reg <= 1'b0;
      ref_reg <= 1'b0;
      boot_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      er_addr_reg <= er_addr_next;
      sts_reg <= sts_next;
      rd_reg <= rd_next;
      unlock_en_reg <= unlock_en_next;
      issued_reg <= issued_next;
      susp_reg <= susp_next;
      sus_req_reg <= sus_req_next;
      rp_reg <= rp_next;
      ulk_reg <= ulk_next;
      seq_reg <= seq_next;
      tmo_reg <= tmo_next;
      ref_reg <= ref_next;
      boot_reg <= boot_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reset_powerdown_n = rp_reg;
  assign unlock_req = ulk_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_confirm_follows: assert property (@(posedge clock) disable iff (!rst_n) // R4
    $rose(st_reg == S_ER_CONF) |-> $past(st_reg) == S_ER_SETUP)
    else $error("confirm without setup");
  a_busy_keeps_poll: assert property (@(posedge clock) disable iff (!rst_n) // R9
    (st_reg == S_POLL && b_done && !bus_rdata[STS_READY] && !sus_req_reg
      && cnt_reg < POLL_LIMIT) |=> st_reg == S_POLL)
    else $error("poll left while flash busy");
  a_clear_then_array: assert property (@(posedge clock) disable iff (!rst_n) // R13
    $rose(st_reg == S_RDARR) |-> $past(st_reg) == S_CLR)
    else $error("read array without status clear");
  a_reset_pulse: assert property (@(posedge clock) disable iff (!rst_n) // R24
    $fell(reset_powerdown_n) |-> (!reset_powerdown_n && flash_cs_n)[*8])
    else $error("reset pulse too short");
  a_no_cs_in_reset: assert property (@(posedge clock) disable iff (!rst_n) // R21
    !reset_powerdown_n |-> flash_cs_n) else $error("chip select during reset");
  a_susp_refuses: assert property (@(posedge clock) disable iff (!rst_n) // R16
    (st_reg == S_SUSP && cmd_wr && op == OP_ERASE) |=> ref_reg && st_reg == S_SUSP)
    else $error("erase accepted while suspended");
  a_susp_held: assert property (@(posedge clock) disable iff (!rst_n) // R22
    $fell(susp_reg) |-> $past(st_reg) inside {S_RES_CMD, S_RST_LOW, S_ST_RD})
    else $error("suspended flag dropped early");
  a_unlock_gated: assert property (@(posedge clock) disable iff (!rst_n) // R20
    unlock_req |-> $past(unlock_en_reg, 1) || $past(unlock_req))
    else $error("unlock without enable");
  a_rdata_slot: assert property (@(posedge clock) disable iff (!rst_n)
    !$past(reg_rd) |-> reg_rdata == '0) else $error("read data outside slot");
endmodule : fsc_ctrl

// ==== fsc_ctrl_test.sv ====
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module fsc_ctrl_test;
  import fsc_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic vpp_low = 1'b0, fail_erase = 1'b0;
  logic [RA_W-1:0] reg_addr = 4'h0;
  logic [RD_W-1:0] reg_wdata = 32'h0, reg_rdata, st;
  logic flash_cs_n, flash_we_n, flash_oe_n, flash_dq_oe, reset_powerdown_n, unlock_req;
  logic [FA_W-1:0] flash_addr;
  logic [FD_W-1:0] flash_dq_out, flash_dq_in;
  int error_cnt = 0;
  int num_checks = 0;
  // 25 MHz clock
  always #20 clock = ~clock;
  fsc_ctrl #(.POLL_LIMIT(24'h000BB8)) dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .flash_cs_n, .flash_we_n, .flash_oe_n, .flash_addr, .flash_dq_out,
    .flash_dq_oe, .flash_dq_in, .reset_powerdown_n, .unlock_req);
  fsc_flash_model flash (.clock(clock), .vpp_low(vpp_low), .fail_erase(fail_erase),
    .cs_n(flash_cs_n), .we_n(flash_we_n), .oe_n(flash_oe_n), .addr(flash_addr),
    .dq(flash_dq_out), .rp_n(reset_powerdown_n), .unlock(unlock_req), .dq_o(flash_dq_in));
  ////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input string what, input logic [RD_W-1:0] seen, input logic [RD_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [RA_W-1:0] a, input logic [RD_W-1:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [RA_W-1:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 st = reg_rdata;
  endtask : rd
  task automatic wait_bit(input int b, input logic v);
    repeat (600) begin
      rd(REG_STAT);
      if (st[b] === v) return;
    end
    check("wait", 32'h0, 32'h1);
    complete_run();
  endtask : wait_bit
  task automatic erase(input logic [FA_W-1:0] a);
    wr(REG_ADDR, RD_W'(a));
    wr(REG_CMD, RD_W'(OP_ERASE));
    wait_bit(ST_BUSY, 1'b0);
  endtask : erase
  task automatic read_at(input logic [FA_W-1:0] a);
    wr(REG_ADDR, RD_W'(a));
    wr(REG_CMD, RD_W'(OP_READ));
    wait_bit(ST_BUSY, 1'b0);
    rd(REG_RDATA);
  endtask : read_at
  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_erase;
    erase(18'h04000);
    check("status", st[7:0], 32'h80);
    read_at(18'h04010);
    check("erased", st[7:0], 32'hFF);
  endtask : t_erase
  task automatic t_faults;
    fail_erase <= 1'b1;
    erase(18'h08000);
    fail_erase <= 1'b0;
    check("erase fail", st[STS_ERASE_FAIL], 32'h1);
    vpp_low <= 1'b1;
    erase(18'h08000);
    vpp_low <= 1'b0;
    check("supply", st[5:3], 32'h5);
    wr(REG_CTRL, 32'h0);
    erase(18'h3C000);
    check("boot", st[STS_ERASE_FAIL], 32'h1);
    check("boot flag", st[ST_BOOT_ERR], 32'h1);
    erase(18'h08000);
    check("cleared", st[7:0], 32'h80);
    wr(REG_CTRL, 32'h1);
    erase(18'h3C000);
    check("unlocked boot", st[7:0], 32'h80);
  endtask : t_faults
  task automatic t_suspend;
    wr(REG_ADDR, 32'h10000);
    wr(REG_CMD, RD_W'(OP_ERASE));
    repeat (200) @(posedge clock) if (flash_oe_n === 1'b0) break;
    check("poll start", flash_oe_n, 32'h0);
    if (flash_oe_n !== 1'b0) complete_run();
    wr(REG_CMD, RD_W'(OP_SUSPEND));
    wait_bit(ST_SUSPENDED, 1'b1);
    check("suspended", st[7:6], 32'h3);
    read_at(18'h20000);
    check("other block", st[7:0], 32'h5A);
    wr(REG_CMD, RD_W'(OP_ERASE));
    wr(REG_CMD, RD_W'(OP_STATUS));
    wait_bit(ST_BUSY, 1'b0);
    check("suspend status", st[7:0], 32'hC0);
    check("refused", st[ST_REFUSED], 32'h1);
    wr(REG_CMD, RD_W'(OP_RESUME));
    wait_bit(ST_BUSY, 1'b0);
    check("resumed", st[7:0], 32'h80);
    read_at(18'h10000);
    check("resumed block", st[7:0], 32'hFF);
  endtask : t_suspend
  task automatic t_reset_pin;
    wr(REG_CMD, RD_W'(OP_RESET));
    repeat (50) @(posedge clock) if (reset_powerdown_n === 1'b0) break;
    check("reset pin", reset_powerdown_n, 32'h0);
    if (reset_powerdown_n !== 1'b0) complete_run();
    wait_bit(ST_BUSY, 1'b0);
    check("status after reset", st[7:0], 32'h0);
  endtask : t_reset_pin
  // main sequence
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    check("idle pins", {flash_cs_n, flash_we_n, flash_oe_n, reset_powerdown_n}, 32'hF);
    rd(4'hF);
    check("unmapped", st, 32'h0);
    t_erase();
    t_faults();
    t_suspend();
    t_reset_pin();
    complete_run();
  end
endmodule : fsc_ctrl_test

// ==== fsc_flash_model.sv ====
// behavioural flash device answering the controller's pins
`timescale 1ns/1ps
module fsc_flash_model #(
  parameter int ERASE_CYC = 120,
  parameter logic [17:0] MASK = 18'h3C000,
  parameter logic [17:0] BOOT = 18'h3C000
) (
  // timing and fault knobs
  input wire logic clock,
  input wire logic vpp_low,
  input wire logic fail_erase,
  // device pins
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [17:0] addr,
  input wire logic [7:0] dq,
  input wire logic rp_n,
  input wire logic unlock,
  output logic [7:0] dq_o
);
  logic we_q = 1'b1, setup = 1'b0, susp = 1'b0, sreq = 1'b0;
  logic ef = 1'b0, pf = 1'b0, vl = 1'b0, rd_st = 1'b0;
  logic [7:0] cnt = 8'h00, last = 8'h00;
  logic [17:0] blk = 18'h00000, erased = 18'h3FFFF;
  logic [7:0] sr;
  logic [7:0] arr;
  ////////////////////////////////////////////////////////////////////////
  // status byte and read path, released bus shows a moving pattern
  assign sr = {cnt == 8'h00 || susp, susp, ef, pf, vl, 3'h0};
  assign arr = ((addr & MASK) == erased) ? 8'hFF : 8'h5A;
  assign dq_o = (!cs_n && !oe_n && rp_n) ? (rd_st ? sr : arr) : ~last;
  // erase timing and command decoding
  always @(posedge clock) begin
    last <= dq_o;
    we_q <= we_n;
    if (!rp_n) begin
      {setup, susp, sreq, ef, pf, vl, rd_st} <= 7'h00;
      cnt <= 8'h00;
    end else begin
      if (cnt != 8'h00 && !susp) cnt <= cnt - 8'h01;
      if (cnt == 8'h01 && !susp && fail_erase) ef <= 1'b1;
      if (cnt == 8'h01 && !susp && !fail_erase) erased <= blk;
      if (sreq && cnt != 8'h00) susp <= 1'b1;
      if (cnt == 8'h00) sreq <= 1'b0;
      if (vpp_low && cnt != 8'h00) begin
        vl <= 1'b1;
        cnt <= 8'h00;
        susp <= 1'b0;
      end
      if (we_n && !we_q && !cs_n) begin
        setup <= 1'b0;
        if (setup && dq != 8'h05) begin
          {ef, pf, rd_st} <= 3'h7;
        end else if (setup) begin
          rd_st <= 1'b1;
          blk <= addr & MASK;
          if (vpp_low) {ef, vl} <= 2'h3;
          else if ((addr & MASK) == BOOT && !unlock) ef <= 1'b1;
          else cnt <= 8'(ERASE_CYC);
        end else begin
          case (dq)
            8'h01: rd_st <= 1'b0;
            8'h02: rd_st <= 1'b1;
            8'h03: {ef, pf, vl} <= 3'h0;
            8'h04: setup <= 1'b1;
            8'h06: sreq <= 1'b1;
            8'h07: {sreq, susp, rd_st} <= 3'h1;
            default: rd_st <= rd_st;
          endcase
        end
      end
    end
  end
endmodule : fsc_flash_model

// ==== fsc_pkg.sv ====
// constants and register layout of the flash erase/suspend host controller
//
// Summary of operation
// R1 - device flags erase failure when erase pulses run out unverified; host reports it
// R2 - device flags program failure on a byte that will not program; host reports it
// R3 - supply low latches its flag and aborts work, even while suspended
// R4 - erase is setup write then confirm write; block address taken at confirm
// R5 - a completed erase leaves the whole block at logic one
// R6 - a non-confirm write after setup sets both failure flags
// R7 - after a bad erase sequence the device reads back status, not array
// R8 - erase runs program, verify, erase, verify internally in that order
// R9 - ready bit reads zero for the whole erase; host keeps polling
// R10 - erase failure shows in bit five within a bounded time
// R11 - supply outside limits skips the erase and sets bits five and three
// R12 - after erase, reads give status until the read array command
// R13 - host checks failure flags, then clears status before the next job
// R14 - suspend pauses the erase at an internal point, not at once
// R15 - after suspend the host polls status until suspension is confirmed
// R16 - while suspended only read array elsewhere, resume and read status are valid
// R17 - chip select high while suspended gives standby, erase kept
// R18 - resume needs chip select low, then the resume write; erase then finishes
// R19 - program or erase with supply below lockout sets an error bit
// R20 - boot block work without unlock voltage fails with bit four or five
// R21 - active mode whenever chip select is low and reset pin high
// R22 - suspended flag stays set until resume is written
// R23 - a command write needs both write strobe and chip select low
// R24 - reset pin low aborts any job and clears status
// R25 - failure flags stay set until status is cleared or the device reset
package fsc_pkg;
  // clock and pin timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLK_MHZ = 25;
  localparam int SETUP_NS = 40;
  localparam int STROBE_NS = 200;
  localparam int RP_LOW_NS = 1000;
  localparam int RP_RECOV_NS = 300;
  localparam int POLL_TIMEOUT_US = 1500;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_LOW_CYC = (RP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_RECOV_CYC = (RP_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POLL_TIMEOUT_CYC = POLL_TIMEOUT_US * CLK_MHZ;
  // widths
  localparam int FA_W = 18;
  localparam int FD_W = 8;
  localparam int RA_W = 4;
  localparam int RD_W = 32;
  localparam int CNT_W = 24;
  // device status bit positions
  localparam int STS_READY = 7;
  localparam int STS_SUSP = 6;
  localparam int STS_ERASE_FAIL = 5;
  localparam int STS_PROG_FAIL = 4;
  localparam int STS_SUPPLY_LOW = 3;
  // own register offsets
  localparam logic [RA_W-1:0] REG_CTRL = 4'h0;
  localparam logic [RA_W-1:0] REG_ADDR = 4'h1;
  localparam logic [RA_W-1:0] REG_CMD = 4'h2;
  localparam logic [RA_W-1:0] REG_STAT = 4'h3;
  localparam logic [RA_W-1:0] REG_RDATA = 4'h4;
  // control and host status fields
  localparam int CTRL_UNLOCK = 0;
  localparam int ST_BUSY = 8;
  localparam int ST_SUSPENDED = 9;
  localparam int ST_SEQ_ERR = 10;
  localparam int ST_TIMEOUT = 11;
  localparam int ST_REFUSED = 12;
  localparam int ST_BOOT_ERR = 13;
  // operation codes written to the command register
  localparam logic [2:0] OP_ERASE = 3'h1;
  localparam logic [2:0] OP_SUSPEND = 3'h2;
  localparam logic [2:0] OP_RESUME = 3'h3;
  localparam logic [2:0] OP_READ = 3'h4;
  localparam logic [2:0] OP_STATUS = 3'h5;
  localparam logic [2:0] OP_RESET = 3'h6;
endpackage : fsc_pkg

// ==== fsc_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module fsc_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // async in, synced out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] dout_reg;
  logic [W-1:0] dout_next;

  // first stage feeds only the second
  always_comb begin
    meta_next = din;
    dout_next = meta_reg;
  end

  // register both stages
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_reg <= '0;
      dout_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      dout_reg <= dout_next;
    end
  end

  assign dout = dout_reg;
endmodule : fsc_sync
